//--- src/tis_map.svh
// Constants for the trap and interrupt sequencer
// Assumes inclusion by the sequencer module and the bench top only
`ifndef TIS_MAP_SVH
`define TIS_MAP_SVH
`define TIS_STACK_FLOOR      16'h0800
`define TIS_LVL_MATH         4'hb
`define TIS_LVL_ADDR         4'hc
`define TIS_LVL_STACK        4'hd
`define TIS_LVL_OSC          4'he
`define TIS_LVL_HARD_MIN     4'hc
`define TIS_HARD_MASK        4'he
`define TIS_BIT_OVF          31
`define TIS_BIT_CAT          39
`define TIS_CONFLICT_BIT     15
`define TIS_TRAP_PRIO_BIT    3
`define TIS_ALT_VEC_OFS      24'h000080
`define TIS_VEC_BASE         24'h000004
`define TIS_IRQ_VEC_BASE     24'h000014
`define TIS_NUM_IRQ          8
`endif

//--- src/tis_pkg.sv
// Types for the trap and interrupt sequencer
// Assumes nothing beyond the map header
package tis_pkg;
    typedef enum logic [3:0] {
        TIS_IDLE   = 4'b0001,
        TIS_PUSH   = 4'b0010,
        TIS_VECTOR = 4'b0100,
        TIS_POP    = 4'b1000
    } tis_state_t;
endpackage : tis_pkg

//--- src/tis_sequencer.sv
// Trap detection, priority and interrupt entry/exit sequencing
// Assumes the core pipeline on the same clock, pulses one cycle long
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tis_map.svh"
module tis_sequencer
    import tis_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cyc_start,
    input  wire logic        div_by_zero,
    input  wire logic        acc_op,
    input  wire logic [40:0] acc_result,
    input  wire logic        ovf_a_trap_en,
    input  wire logic        ovf_b_trap_en,
    input  wire logic        acc_sel_b,
    input  wire logic        cat_ovf_trap_en,
    input  wire logic        guard_bits_used,
    input  wire logic        saturation_on,
    input  wire logic [4:0]  shift_amount,
    input  wire logic [4:0]  shift_max,
    input  wire logic        shift_op,
    input  wire logic        data_access,
    input  wire logic        word_access,
    input  wire logic [15:0] data_addr,
    input  wire logic        dual_op,
    input  wire logic        y_space_access,
    input  wire logic [15:0] x_space_top,
    input  wire logic [15:0] y_space_base,
    input  wire logic [15:0] data_mem_top,
    input  wire logic        prog_data_fetch,
    input  wire logic        instr_fetch,
    input  wire logic [23:0] fetch_addr,
    input  wire logic [23:0] prog_mem_top,
    input  wire logic [23:0] vector_space_top,
    input  wire logic        sp_load,
    input  wire logic [15:0] sp_value,
    input  wire logic [15:0] stack_limit_register,
    input  wire logic        osc_fail,
    input  wire logic        trap_ack,
    input  wire logic [3:0]  trap_ack_level,
    input  wire logic [7:0]  interrupt_flag_registers,
    input  wire logic [7:0]  interrupt_enable_registers,
    input  wire logic [23:0] irq_prio_flat,
    input  wire logic [3:0]  cpu_priority_level_in,
    input  wire logic        cpu_priority_level_wr,
    input  wire logic [23:0] pc_in,
    input  wire logic [7:0]  status_low_byte,
    input  wire logic        return_from_interrupt_instr,
    input  wire logic [23:0] stack_pc_in,
    input  wire logic [7:0]  stack_status_in,
    input  wire logic        alt_vector_select,
    input  wire logic        shadow_save,
    input  wire logic        shadow_restore,
    input  wire logic [4:0]  flags_in,
    input  wire logic [63:0] work_regs_in,
    output logic [3:0]       cpu_priority_level,
    output logic             trap_priority_bit,
    output logic             stall_code,
    output logic             push_req,
    output logic [23:0]      push_pc,
    output logic [7:0]       push_status,
    output logic             vector_req,
    output logic [23:0]      vector_addr,
    output logic             pop_done,
    output logic [23:0]      pop_pc,
    output logic [7:0]       pop_status,
    output logic [3:0]       trap_pending,
    output logic             conflict_reset,
    output logic             trap_conflict_reset_flag,
    output logic [4:0]       shadow_flags,
    output logic [63:0]      shadow_work_regs
);

    // ************************************
    // Helper functions
    // ************************************
    function automatic logic [3:0] prio_of(input logic [23:0] flat, input int idx);
        logic [2:0] p;
        p = flat[idx*3 +: 3];
        return {1'b0, p};
    endfunction : prio_of

    function automatic logic [3:0] trap_level(input logic [3:0] t);
        logic [3:0] l;
        l = 4'h0;
        if (t[0]) l = `TIS_LVL_MATH;
        if (t[1]) l = `TIS_LVL_ADDR;
        if (t[2]) l = `TIS_LVL_STACK;
        if (t[3]) l = `TIS_LVL_OSC;
        return l;
    endfunction : trap_level

    function automatic logic [3:0] hard_only(input logic [3:0] t);
        return t & `TIS_HARD_MASK;
    endfunction : hard_only

    function automatic logic [23:0] vec_of(input logic [23:0] base, input logic [2:0] idx);
        return base + 24'({idx, 1'b0});
    endfunction : vec_of

    // ************************************
    // Trap detection
    // ************************************
    logic       ovf_en;
    logic       math_det;
    logic       addr_det;
    logic       stack_det;
    logic       unimpl_data;
    logic       osc_s1;
    logic       osc_s2;
    logic       osc_d;
    logic [3:0] new_traps;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_s1 <= 1'b0;
            osc_s2 <= 1'b0;
            osc_d  <= 1'b0;
        end else begin
            osc_s1 <= osc_fail;
            osc_s2 <= osc_s1;
            osc_d  <= osc_s2;
        end
    end

    always_comb begin
        ovf_en   = acc_sel_b ? ovf_b_trap_en : ovf_a_trap_en;
        math_det = div_by_zero
            || (acc_op && ovf_en && !guard_bits_used
                && (acc_result[`TIS_BIT_OVF+1] != acc_result[`TIS_BIT_OVF]))
            || (acc_op && cat_ovf_trap_en && !saturation_on
                && (acc_result[`TIS_BIT_CAT+1] != acc_result[`TIS_BIT_CAT]))
            || (shift_op && (shift_amount > shift_max));
        unimpl_data = (data_addr > data_mem_top)
            || (dual_op && !y_space_access && (data_addr > x_space_top))
            || (dual_op && y_space_access && (data_addr < y_space_base));
        addr_det = (data_access && ((word_access && data_addr[0]) || unimpl_data))
            || (prog_data_fetch && (fetch_addr > prog_mem_top))
            || (instr_fetch && (fetch_addr <= vector_space_top))
            || (instr_fetch && (fetch_addr > prog_mem_top));
        stack_det = sp_load && ((sp_value > stack_limit_register)
            || (sp_value < `TIS_STACK_FLOOR));
        new_traps = {osc_s2 && !osc_d, stack_det, addr_det, math_det};
    end

    // ************************************
    // Trap pending and conflict
    // ************************************
    logic [3:0] active_lvl;
    logic [3:0] next_trap_pending;
    logic       conflict;
    logic [3:0] ack_mask;

    always_comb begin
        active_lvl = trap_level(trap_pending);
        conflict   = 1'b0;
        for (int i = 1; i < 4; i++) begin
            if (new_traps[i] && (trap_level(4'(1 << i)) < active_lvl)
                && (active_lvl >= `TIS_LVL_HARD_MIN))
                conflict = 1'b1;
        end
        ack_mask = 4'h0;
        if (trap_ack) begin
            for (int i = 0; i < 4; i++)
                if (trap_level(4'(1 << i)) == trap_ack_level)
                    ack_mask[i] = 1'b1;
        end
        next_trap_pending = (trap_pending & ~ack_mask) | new_traps;
    end

    always_ff @(posedge clk) begin
        if (!rst_n || conflict_reset) begin
            trap_pending <= 4'h0;
        end else begin
            trap_pending <= next_trap_pending;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conflict_reset           <= 1'b0;
            trap_conflict_reset_flag <= 1'b0;
        end else begin
            conflict_reset <= conflict;
            if (conflict)
                trap_conflict_reset_flag <= 1'b1;
        end
    end

    // ************************************
    // Code stall on hard traps
    // ************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stall_code <= 1'b0;
        end else begin
            stall_code <= |hard_only(next_trap_pending);
        end
    end

    // ************************************
    // Interrupt arbitration
    // ************************************
    logic [7:0] irq_pend;
    logic [3:0] best_lvl;
    logic [2:0] best_idx;
    logic       take_irq;
    logic       take_trap;
    logic [1:0] trap_idx;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pend <= 8'h00;
        end else if (cyc_start) begin
            irq_pend <= interrupt_flag_registers & interrupt_enable_registers;
        end
    end

    always_comb begin
        best_lvl = 4'h0;
        best_idx = 3'h0;
        for (int i = `TIS_NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_pend[i] && (prio_of(irq_prio_flat, i) >= best_lvl)) begin
                best_lvl = prio_of(irq_prio_flat, i);
                best_idx = 3'(i);
            end
        end
        trap_idx = 2'h0;
        for (int i = 0; i < 4; i++)
            if (trap_pending[i]) trap_idx = 2'(i);
        take_trap = (active_lvl > cpu_priority_level) && !conflict;
        take_irq  = !take_trap && (|irq_pend)
            && (best_lvl > cpu_priority_level);
    end

    // ************************************
    // Entry and exit sequencer
    // ************************************
    tis_state_t state;
    logic [3:0] entry_lvl;
    logic       entry_trap;
    logic [23:0] entry_vec;

    always_ff @(posedge clk) begin
        if (!rst_n || conflict_reset) begin
            state      <= TIS_IDLE;
            entry_lvl  <= 4'h0;
            entry_trap <= 1'b0;
            entry_vec  <= 24'h0;
        end else begin
            case (state)
                TIS_IDLE: begin
                    if (return_from_interrupt_instr) begin
                        state <= TIS_POP;
                    end else if (cyc_start && (take_trap || take_irq)) begin
                        state      <= TIS_PUSH;
                        entry_trap <= take_trap;
                        entry_lvl  <= take_trap ? active_lvl : best_lvl;
                        entry_vec  <= take_trap
                            ? vec_of(`TIS_VEC_BASE, {1'b0, trap_idx})
                            : vec_of(`TIS_IRQ_VEC_BASE, best_idx);
                    end
                end
                TIS_PUSH:   state <= TIS_VECTOR;
                TIS_VECTOR: state <= TIS_IDLE;
                TIS_POP:    state <= TIS_IDLE;
                default:    state <= TIS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            push_req    <= 1'b0;
            push_pc     <= 24'h0;
            push_status <= 8'h00;
        end else begin
            push_req <= (state == TIS_PUSH);
            if (state == TIS_PUSH) begin
                push_pc     <= pc_in;
                push_status <= status_low_byte;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vector_req  <= 1'b0;
            vector_addr <= 24'h0;
        end else begin
            vector_req <= (state == TIS_VECTOR);
            if (state == TIS_VECTOR)
                vector_addr <= alt_vector_select
                    ? (entry_vec + `TIS_ALT_VEC_OFS) : entry_vec;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pop_done   <= 1'b0;
            pop_pc     <= 24'h0;
            pop_status <= 8'h00;
        end else begin
            pop_done <= (state == TIS_POP);
            if (state == TIS_POP) begin
                pop_pc     <= stack_pc_in;
                pop_status <= stack_status_in;
            end
        end
    end

    // ************************************
    // Priority level and trap bit
    // ************************************
    always_ff @(posedge clk) begin
        if (!rst_n || conflict_reset) begin
            cpu_priority_level <= 4'h0;
            trap_priority_bit  <= 1'b0;
        end else if (state == TIS_VECTOR) begin
            cpu_priority_level <= entry_lvl;
            trap_priority_bit  <= entry_trap;
        end else if (state == TIS_POP) begin
            cpu_priority_level <= {trap_priority_bit & stack_status_in[7],
                                   stack_status_in[7:5]};
            trap_priority_bit  <= 1'b0;
        end else if (cpu_priority_level_wr) begin
            cpu_priority_level <= cpu_priority_level_in;
            trap_priority_bit  <= cpu_priority_level_in[`TIS_TRAP_PRIO_BIT];
        end
    end

    // ************************************
    // Shadow registers
    // ************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_flags     <= 5'h00;
            shadow_work_regs <= 64'h0;
        end else if (shadow_save) begin
            shadow_flags     <= flags_in;
            shadow_work_regs <= work_regs_in;
        end
    end

endmodule : tis_sequencer
`default_nettype wire

//--- sim/tis_sequencer_monitor.sv
// Port checks for the trap and interrupt sequencer
// Assumes a bind into tis_sequencer, one clock, sync rst_n
`timescale 1ns/1ns
`default_nettype none
module tis_sequencer_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        div_by_zero,
    input wire logic        shift_op,
    input wire logic [4:0]  shift_amount,
    input wire logic [4:0]  shift_max,
    input wire logic        sp_load,
    input wire logic [15:0] sp_value,
    input wire logic        return_from_interrupt_instr,
    input wire logic        alt_vector_select,
    input wire logic        shadow_save,
    input wire logic [4:0]  flags_in,
    input wire logic        stall_code,
    input wire logic        push_req,
    input wire logic        vector_req,
    input wire logic [23:0] vector_addr,
    input wire logic        pop_done,
    input wire logic [3:0]  trap_pending,
    input wire logic        conflict_reset,
    input wire logic        trap_conflict_reset_flag,
    input wire logic [4:0]  shadow_flags
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_DIV_TRAP: assert property (div_by_zero |-> ##[1:2] trap_pending[0])
        else $error("divide by zero gave no math trap");
    AST_SHIFT_TRAP: assert property (shift_op && shift_amount > shift_max |-> ##[1:2] trap_pending[0])
        else $error("oversized shift gave no math trap");
    AST_STACK_LOW: assert property (sp_load && sp_value < 16'h0800 |-> ##[1:2] trap_pending[2])
        else $error("stack underflow gave no stack trap");
    AST_HARD_STALL: assert property (|trap_pending[3:1] |-> ##[0:1] stall_code)
        else $error("hard trap pending without stall");
    AST_CONFLICT_FLAG: assert property (conflict_reset |-> ##[0:1] trap_conflict_reset_flag)
        else $error("conflict reset without flag");
    AST_PUSH_VECTOR: assert property (push_req |=> vector_req)
        else $error("push not followed by vector");
    AST_ALT_TABLE: assert property (vector_req |-> vector_addr[7] == alt_vector_select)
        else $error("vector from wrong table");
    AST_RETURN_POP: assert property (return_from_interrupt_instr |-> ##2 pop_done)
        else $error("return gave no pop");
    AST_SHADOW_SAVE: assert property (shadow_save |=> shadow_flags == $past(flags_in))
        else $error("shadow flags not saved");
endmodule : tis_sequencer_monitor
`default_nettype wire

//--- sim/tis_core_model.sv
// Core pipeline model: keeps the stacked frames for return
// Assumes the sequencer on the same clock and sync rst_n
`timescale 1ns/1ns
`default_nettype none
module tis_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        push_req,
    input  wire logic [23:0] push_pc,
    input  wire logic [7:0]  push_status,
    input  wire logic        pop_done,
    output logic [23:0]      stack_pc_in,
    output logic [7:0]       stack_status_in
);
    logic [31:0] frames [0:3];
    logic [1:0]  depth;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            depth <= 2'd0;
        end else if (push_req) begin
            frames[depth] <= {push_status, push_pc};
            depth         <= depth + 2'd1;
        end else if (pop_done && depth != 2'd0) begin
            depth <= depth - 2'd1;
        end
    end
    // Empty stack shows junk, not a stale frame
    assign {stack_status_in, stack_pc_in} = (depth != 2'd0) ? frames[depth - 2'd1] : 32'h5aa5c33c;
endmodule : tis_core_model
`default_nettype wire

//--- sim/trap_and_interrupt_sequencer_tb_top.sv
// Self-checking bench for the trap and interrupt sequencer
// Assumes the core model and the monitor compiled before it
`timescale 1ns/1ns
`default_nettype none
`include "tis_map.svh"
module trap_and_interrupt_sequencer_tb_top;
    logic clk, rst_n, cyc_start, div_by_zero, acc_op, ovf_a_trap_en, ovf_b_trap_en, acc_sel_b;
    logic cat_ovf_trap_en, guard_bits_used, saturation_on, shift_op, data_access, word_access;
    logic dual_op, y_space_access, prog_data_fetch, instr_fetch, sp_load, osc_fail, trap_ack;
    logic cpu_priority_level_wr, return_from_interrupt_instr, alt_vector_select, shadow_save;
    logic shadow_restore, trap_priority_bit, stall_code, push_req, vector_req, pop_done;
    logic conflict_reset, trap_conflict_reset_flag;
    logic [40:0] acc_result;
    logic [4:0]  shift_amount, shift_max, flags_in, shadow_flags;
    logic [15:0] data_addr, x_space_top, y_space_base, data_mem_top, sp_value, stack_limit_register;
    logic [23:0] fetch_addr, prog_mem_top, vector_space_top, irq_prio_flat, pc_in, stack_pc_in;
    logic [23:0] push_pc, vector_addr, pop_pc;
    logic [7:0]  interrupt_flag_registers, interrupt_enable_registers, status_low_byte;
    logic [7:0]  stack_status_in, push_status, pop_status;
    logic [3:0]  trap_ack_level, cpu_priority_level_in, cpu_priority_level, trap_pending;
    logic [63:0] work_regs_in, shadow_work_regs;
    int          fails, tests_run, push_cnt, conf_cnt;
    logic [31:0] push_q[$];
    logic [28:0] vec_q[$];
    logic [31:0] pop_q[$];
    logic [3:0]  lvl;
    logic [28:0] v_exp;
    tis_sequencer dut (.*);
    tis_core_model u_core (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic clr;
        @(posedge clk);
        {cyc_start, div_by_zero, acc_op, shift_op, data_access, dual_op, prog_data_fetch,
         instr_fetch, sp_load, osc_fail, trap_ack, cpu_priority_level_wr, word_access,
         return_from_interrupt_instr, shadow_save, shadow_restore, ovf_a_trap_en,
         cat_ovf_trap_en} <= '0;
    endtask : clr
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic trap_case(input int k);
        logic [3:0] l;
        logic [3:0] b;
        l = (k < 4) ? `TIS_LVL_MATH : (k < 9) ? `TIS_LVL_ADDR : (k < 11) ? `TIS_LVL_STACK : `TIS_LVL_OSC;
        b = 4'h1 << (l - `TIS_LVL_MATH);
        @(posedge clk);
        case (k)
            0: div_by_zero <= 1'b1;
            1: {shift_op, shift_amount} <= {1'b1, 5'd9};
            2: {acc_op, ovf_a_trap_en, acc_sel_b, acc_result} <= {3'b110, 41'h001_0000_0000};
            3: {acc_op, cat_ovf_trap_en, acc_sel_b, acc_result} <= {3'b111, 41'h100_0000_0000};
            4: {data_access, word_access, data_addr} <= {2'b11, 16'h0101};
            5: {data_access, data_mem_top, data_addr} <= {1'b1, 16'h7fff, 16'h8000};
            6: {data_access, dual_op, x_space_top, data_addr} <= {2'b11, 16'h3fff, 16'h4000};
            7: {prog_data_fetch, prog_mem_top, fetch_addr} <= {1'b1, 24'h00ffff, 24'h010000};
            8: {instr_fetch, vector_space_top, fetch_addr} <= {1'b1, 24'h0000ff, 24'h000080};
            9: {sp_load, sp_value} <= {1'b1, 16'h07fe};
            10: {sp_load, stack_limit_register, sp_value} <= {1'b1, 16'h1000, 16'h1002};
            default: osc_fail <= 1'b1;
        endcase
        clr();
        tick(4);
        #1;
        chk("trap_pending", b, trap_pending);
        chk("stall_code", |b[3:1], stall_code);
        @(posedge clk);
        {trap_ack, trap_ack_level} <= {1'b1, l};
        clr();
        tick(2);
        #1;
        chk("trap_cleared", 5'h00, {trap_pending, stall_code});
    endtask : trap_case
    task automatic irq(input logic [3:0] pri, input logic alt, input logic take);
        logic [2:0]  idx;
        logic [23:0] pc;
        int          c;
        idx = 3'($urandom);
        pc = 24'($urandom);
        c = push_cnt;
        @(posedge clk);
        {interrupt_flag_registers, interrupt_enable_registers} <= {2{8'h01 << idx}};
        irq_prio_flat <= 24'(pri[2:0]) << (3 * idx);
        {alt_vector_select, pc_in, status_low_byte} <= {alt, pc, lvl[2:0], 5'h00};
        cyc_start <= 1'b1;
        if (take) begin
            push_q.push_back({lvl[2:0], 5'h00, pc});
            vec_q.push_back({1'b0, pri,
                             `TIS_IRQ_VEC_BASE + 24'(2 * idx) + (alt ? `TIS_ALT_VEC_OFS : 24'h0)});
            pop_q.push_back({lvl[2:0], 5'h00, pc});
        end
        @(posedge clk);
        clr();
        tick(4);
        chk("irq_taken", take, push_cnt - c);
        {interrupt_flag_registers, interrupt_enable_registers} <= 16'h0000;
        cyc_start <= 1'b1;
        @(posedge clk);
        return_from_interrupt_instr <= take;
        clr();
        if (take) begin
            tick(3);
            #1;
            chk("restored_level", lvl, cpu_priority_level);
        end
    endtask : irq
    task automatic setlvl(input logic [3:0] v);
        @(posedge clk);
        {cpu_priority_level_wr, cpu_priority_level_in} <= {1'b1, v};
        lvl = v;
        clr();
    endtask : setlvl
    always @(posedge clk) begin
        if (push_req === 1'b1) begin
            push_cnt++;
            if (push_q.size() != 0) chk("push_frame", push_q.pop_front(), {push_status, push_pc});
        end
        if (vector_req === 1'b1 && vec_q.size() != 0) begin
            v_exp = vec_q.pop_front();
            chk("vector", v_exp[27:0], {cpu_priority_level, vector_addr});
            chk("trap_priority_bit", v_exp[28], trap_priority_bit);
        end
        if (pop_done === 1'b1 && pop_q.size() != 0)
            chk("pop_frame", pop_q.pop_front(), {pop_status, pop_pc});
        if (conflict_reset === 1'b1) conf_cnt++;
    end
    initial begin
        {rst_n, cyc_start, div_by_zero, acc_op, ovf_a_trap_en, ovf_b_trap_en, acc_sel_b,
         cat_ovf_trap_en, guard_bits_used, saturation_on, shift_op, data_access, word_access,
         dual_op, y_space_access, prog_data_fetch, instr_fetch, sp_load, osc_fail, trap_ack,
         cpu_priority_level_wr, return_from_interrupt_instr, alt_vector_select, shadow_save,
         shadow_restore, acc_result, shift_amount, flags_in, data_addr, y_space_base, sp_value,
         fetch_addr, vector_space_top, irq_prio_flat, pc_in, interrupt_flag_registers,
         interrupt_enable_registers, status_low_byte, trap_ack_level, cpu_priority_level_in,
         work_regs_in} = '0;
        {data_mem_top, x_space_top, stack_limit_register, prog_mem_top} = '1;
        shift_max = 5'd8;
        lvl = 4'h0;
        void'($urandom(33568));
        tick(10);
        rst_n <= 1'b1;
        tick(1);
        #1;
        chk("reset_state", 10'h000, {trap_pending, stall_code, cpu_priority_level, trap_conflict_reset_flag});
        for (int k = 0; k < 12; k++) trap_case(k);
        for (int n = 0; n < 4; n++) irq(4'(1 + $urandom % 7), n[0], 1'b1);
        setlvl(4'h6);
        irq(4'h6, 1'b0, 1'b0);
        irq(4'h7, 1'b1, 1'b1);
        setlvl(4'h0);
        @(posedge clk);
        {div_by_zero, cyc_start, alt_vector_select} <= 3'b111;
        {pc_in, status_low_byte} <= {24'h00a5c3, 8'h00};
        push_q.push_back({8'h00, 24'h00a5c3});
        vec_q.push_back({1'b1, `TIS_LVL_MATH, `TIS_VEC_BASE + `TIS_ALT_VEC_OFS});
        pop_q.push_back({8'h00, 24'h00a5c3});
        @(posedge clk);
        div_by_zero <= 1'b0;
        clr();
        tick(3);
        {trap_ack, trap_ack_level} <= {1'b1, `TIS_LVL_MATH};
        return_from_interrupt_instr <= 1'b1;
        clr();
        tick(3);
        #1;
        chk("trap_exit", 5'h00, {cpu_priority_level, trap_priority_bit});
        chk("trap_acked", 1'b0, trap_pending[0]);
        @(posedge clk);
        {shadow_save, flags_in, work_regs_in} <= {1'b1, 5'h15, {$urandom, $urandom}};
        @(posedge clk);
        {shadow_save, shadow_restore, flags_in, work_regs_in} <= {2'b01, 5'h0a, ~work_regs_in};
        @(posedge clk);
        shadow_restore <= 1'b0;
        #1;
        chk("shadow", {5'h15, ~work_regs_in}, {shadow_flags, shadow_work_regs});
        @(posedge clk);
        {sp_load, sp_value} <= {1'b1, 16'h07fe};
        clr();
        tick(3);
        {data_access, word_access, data_addr} <= {2'b11, 16'h0101};
        clr();
        tick(4);
        #1;
        chk("conflict", {1'b1, 4'h0, 32'd1}, {trap_conflict_reset_flag, trap_pending, conf_cnt});
        test_done();
    end
    initial begin
        #50000;
        fails++;
        test_done();
    end
endmodule : trap_and_interrupt_sequencer_tb_top
bind tis_sequencer tis_sequencer_monitor u_mon (.*);
`default_nettype wire
